// File: iosc_map.svh
// iosc_map.svh : register offsets, field positions, reset values and timing
// counts of the internal oscillator select block.
// assumes: included by bare name; the system clock runs at 100 MHz.
`ifndef IOSC_MAP_SVH
`define IOSC_MAP_SVH

// ----------------------------------------------------------------------------
// clocks and source rates
// ----------------------------------------------------------------------------
`define IOSC_CLK_HZ          100000000
`define IOSC_CLK_MHZ         100
`define IOSC_HF_HZ           16000000
`define IOSC_MF_HZ           500000
`define IOSC_LF_HZ           31250
// phase increment of a 32-bit accumulator that overflows at the given rate
`define IOSC_NCO_INC(hz)     (32'((64'(hz) << 32) / 64'(`IOSC_CLK_HZ)))

// ----------------------------------------------------------------------------
// start-up timing
// ----------------------------------------------------------------------------
`define IOSC_POWER_UP_TIMER_TIME_US    65500
`define IOSC_POWER_UP_TIMER_LF_TICKS   ((`IOSC_POWER_UP_TIMER_TIME_US * `IOSC_LF_HZ + 999999) / 1000000)
`define IOSC_OST_PERIODS     1024
`define IOSC_PLL_LOCK_US     2000
`define IOSC_PLL_LOCK_CYCLES (`IOSC_PLL_LOCK_US * `IOSC_CLK_MHZ)

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define IOSC_OFS_CTRL        5'h00
`define IOSC_OFS_CTRL2       5'h04
`define IOSC_OFS_TRIM        5'h08
`define IOSC_OFS_CFG         5'h0C
`define IOSC_OFS_STATUS      5'h10

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define IOSC_FREQ_SEL_LSB    0
`define IOSC_MF_SEL_BIT      0
`define IOSC_TUNE_LSB        0
`define IOSC_LF_SEL_BIT      7
`define IOSC_MODE_LSB        0
`define IOSC_POWER_UP_TIMER_DIS_BIT    3
`define IOSC_READY_BIT       0
`define IOSC_STATE_LSB       1
`define IOSC_FREQ_SEL_RST    3'h3
`define IOSC_TRIM_SHIFT      7

`endif

// File: iosc_pkg.sv
// iosc_pkg.sv : types shared by the internal oscillator select block.
// assumes: nothing beyond a SystemVerilog compiler.
package iosc_pkg;

    // oscillator configuration chosen for start-up timing
    typedef enum logic [2:0] {
        IOSC_MODE_XPLL  = 3'b000,   // crystal with pll
        IOSC_MODE_XTAL  = 3'b001,   // crystal without pll
        IOSC_MODE_EXT   = 3'b010,   // external clock
        IOSC_MODE_RC    = 3'b011,   // external rc
        IOSC_MODE_INT   = 3'b100    // internal oscillator
    } iosc_mode_t;

    // start-up time-out sequencer
    typedef enum logic [2:0] {
        IOSC_ST_START   = 3'b000,
        IOSC_ST_POWER_UP_TIMER    = 3'b001,
        IOSC_ST_OST     = 3'b010,
        IOSC_ST_PLL     = 3'b011,
        IOSC_ST_RUN     = 3'b100
    } iosc_start_t;

    // ticks of the three raw sources
    typedef struct packed {
        logic hf;
        logic mf;
        logic lf;
    } iosc_ticks_t;

    // whole state of the top module apart from the check counters
    typedef struct packed {
        logic [2:0]  freq_sel;      // freq_select_field
        logic        mf_sel;        // medium_source_select
        logic        lf_sel;        // low_source_select
        logic [5:0]  tune;          // tuning_field
        iosc_mode_t  mode;
        logic        power_up_timer_dis;      // power_up_timer_enable, 1 skips delay
        iosc_start_t st;
        logic        pm_evt;        // current time-out started by pm exit
        logic [23:0] cnt;
        logic [8:0]  hf_div;
        logic [3:0]  mf_div;
        logic        wait_req;
        logic [31:0] rdata;
        logic        int_tick;
        logic        lf_tick;
        logic        prim_tick;
        logic        hold;
    } iosc_state_t;

endpackage

// File: iosc_nco.sv
// iosc_nco.sv : phase accumulator that stands in for one oscillator.
// assumes: the increment is steady or changes only between overflows.
`timescale 1ns/1ps
`default_nettype none

module iosc_nco #(
    parameter int W = 32                    // accumulator width
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    // rate
    input  wire logic [W-1:0] i_inc,
    // tick out
    output logic              o_tick
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] acc;                  // phase
        logic         tick;                 // overflow seen
    } iosc_nco_state_t;

    iosc_nco_state_t s_q;
    iosc_nco_state_t s_d;

    // next phase; the carry out is one period of the source
    always_comb begin
        s_d = s_q;
        {s_d.tick, s_d.acc} = {1'b0, s_q.acc} + {1'b0, i_inc};
    end

    // register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;

endmodule // iosc_nco

`default_nettype wire

// File: iosc_top.sv
// iosc_top.sv : internal oscillator select block with start-up time-out.
// assumes: avalon-mm master on i_clk; i_bor, i_pm_exit, i_osc_tick are
// synchronous one-cycle pulses.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`include "iosc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module iosc_top
    import iosc_pkg::*;
#(
    parameter logic [23:0] POWER_UP_TIMER_LF_TICKS   = 24'(`IOSC_POWER_UP_TIMER_LF_TICKS),
    parameter logic [23:0] OST_PERIODS     = 24'(`IOSC_OST_PERIODS),
    parameter logic [23:0] PLL_LOCK_CYCLES = 24'(`IOSC_PLL_LOCK_CYCLES)
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // avalon-mm slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // device events
    input  wire logic        i_bor,
    input  wire logic        i_pm_exit,
    input  wire logic        i_osc_tick,
    input  wire logic        i_primary_sel_lf,
    // clock ticks and status
    output logic             o_int_tick,
    output logic             o_lf_tick,
    output logic             o_primary_tick,
    output logic             o_startup_hold
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // trimmed increment: base plus signed tune steps of base/128
    function automatic logic [31:0] trim_inc(input logic [31:0] base, input logic [5:0] tune);
        logic signed [39:0] t;
        t = $signed({8'h00, base}) + $signed({{34{tune[5]}}, tune}) * $signed({15'h0000, base[31:7]});
        return t[31:0];
    endfunction

    // divider tap: true when the low k bits of the count are all ones
    function automatic logic div_tap(input logic [8:0] cnt, input logic [3:0] k);
        logic [8:0] mask;
        mask = 9'((10'h001 << k) - 10'h001);
        return (cnt & mask) == mask;
    endfunction

    // crystal modes need the start-up count
    function automatic logic is_crystal(input iosc_mode_t m);
        return (m == IOSC_MODE_XPLL) || (m == IOSC_MODE_XTAL);
    endfunction

    // ------------------------------------------------------------------------
    // sources
    // ------------------------------------------------------------------------
    iosc_state_t s_q;                       // registered state apart from the check counters
    iosc_state_t s_d;                       // its next value
    iosc_ticks_t src;                       // raw source ticks
    logic [31:0] hf_inc;                    // trimmed high rate
    logic [31:0] mf_inc;                    // trimmed medium rate
    logic [31:0] lf_inc;                    // fixed low rate

    assign hf_inc = trim_inc(`IOSC_NCO_INC(`IOSC_HF_HZ), s_q.tune);
    assign mf_inc = trim_inc(`IOSC_NCO_INC(`IOSC_MF_HZ), s_q.tune);
    assign lf_inc = `IOSC_NCO_INC(`IOSC_LF_HZ);

    iosc_nco #(.W(32)) u_hf (.i_clk(i_clk), .i_resetn(i_resetn), .i_inc(hf_inc), .o_tick(src.hf));
    iosc_nco #(.W(32)) u_mf (.i_clk(i_clk), .i_resetn(i_resetn), .i_inc(mf_inc), .o_tick(src.mf));
    iosc_nco #(.W(32)) u_lf (.i_clk(i_clk), .i_resetn(i_resetn), .i_inc(lf_inc), .o_tick(src.lf));

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    logic        req;                       // bus request present
    logic [31:0] rd_mux;                    // read data for the address
    logic        wr_ok;                     // write lands this edge
    logic        mf_tap;                    // medium divider tap helper

    always_comb begin
        s_d    = s_q;
        req    = i_avs_read | i_avs_write;
        wr_ok  = req & ~s_q.wait_req & i_avs_write & i_avs_byteenable[0];
        mf_tap = 1'b0;

        // divider chain counts source ticks
        if (src.hf) begin
            s_d.hf_div = s_q.hf_div + 9'h001;
        end
        if (src.mf) begin
            s_d.mf_div = s_q.mf_div + 4'h1;
        end

        // frequency multiplexer
        case (s_q.freq_sel)
            3'h7: s_d.int_tick = src.hf;                                // 16 MHz
            3'h6: s_d.int_tick = src.hf & div_tap(s_q.hf_div, 4'h1);    // 8 MHz
            3'h5: s_d.int_tick = src.hf & div_tap(s_q.hf_div, 4'h2);    // 4 MHz
            3'h4: s_d.int_tick = src.hf & div_tap(s_q.hf_div, 4'h3);    // 2 MHz
            3'h3: s_d.int_tick = src.hf & div_tap(s_q.hf_div, 4'h4);    // 1 MHz
            3'h2: begin                                                 // 500 kHz
                s_d.int_tick = s_q.mf_sel ? src.mf : (src.hf & div_tap(s_q.hf_div, 4'h5));
            end
            3'h1: begin                                                 // 250 kHz
                mf_tap       = div_tap({5'h00, s_q.mf_div}, 4'h1);
                s_d.int_tick = s_q.mf_sel ? (src.mf & mf_tap) : (src.hf & div_tap(s_q.hf_div, 4'h6));
            end
            default: begin                                              // 31 kHz
                mf_tap = div_tap({5'h00, s_q.mf_div}, 4'h4);
                if (!s_q.lf_sel) begin
                    s_d.int_tick = src.lf;
                end else if (s_q.mf_sel) begin
                    s_d.int_tick = src.mf & mf_tap;
                end else begin
                    s_d.int_tick = src.hf & div_tap(s_q.hf_div, 4'h9);
                end
            end
        endcase

        // low source always out to timer, watchdog and monitor
        s_d.lf_tick   = src.lf;
        // primary path: low source or combined internal clock
        s_d.prim_tick = i_primary_sel_lf ? src.lf : s_d.int_tick;

        // start-up time-out sequencer
        case (s_q.st)
            IOSC_ST_START: begin
                s_d.cnt = '0;
                if (!s_q.pm_evt && !s_q.power_up_timer_dis) begin
                    s_d.st = IOSC_ST_POWER_UP_TIMER;
                end else if (is_crystal(s_q.mode)) begin
                    s_d.st = IOSC_ST_OST;
                end else begin
                    s_d.st = IOSC_ST_RUN;
                end
            end
            IOSC_ST_POWER_UP_TIMER: begin                                         // counts low source ticks
                if (src.lf) begin
                    s_d.cnt = s_q.cnt + 24'h000001;
                    if (s_q.cnt == POWER_UP_TIMER_LF_TICKS - 24'h000001) begin
                        s_d.cnt = '0;
                        s_d.st  = is_crystal(s_q.mode) ? IOSC_ST_OST : IOSC_ST_RUN;
                    end
                end
            end
            IOSC_ST_OST: begin                                          // counts oscillator periods
                if (i_osc_tick) begin
                    s_d.cnt = s_q.cnt + 24'h000001;
                    if (s_q.cnt == OST_PERIODS - 24'h000001) begin
                        s_d.cnt = '0;
                        s_d.st  = (s_q.mode == IOSC_MODE_XPLL) ? IOSC_ST_PLL : IOSC_ST_RUN;
                    end
                end
            end
            IOSC_ST_PLL: begin                                          // lock wait in clock cycles
                s_d.cnt = s_q.cnt + 24'h000001;
                if (s_q.cnt == PLL_LOCK_CYCLES - 24'h000001) begin
                    s_d.cnt = '0;
                    s_d.st  = IOSC_ST_RUN;
                end
            end
            IOSC_ST_RUN: begin
                if (i_pm_exit) begin
                    s_d.st     = IOSC_ST_START;
                    s_d.pm_evt = 1'b1;
                end
            end
            default: begin
                s_d.st = IOSC_ST_START;
            end
        endcase
        // brown-out restarts the full power-up time-out from any state
        if (i_bor) begin
            s_d.st     = IOSC_ST_START;
            s_d.pm_evt = 1'b0;
            s_d.cnt    = '0;
        end
        s_d.hold = (s_d.st != IOSC_ST_RUN);

        // register read mux; unmapped reads return zero
        case (i_avs_address)
            `IOSC_OFS_CTRL:   rd_mux = {29'h0, s_q.freq_sel};
            `IOSC_OFS_CTRL2:  rd_mux = {31'h0, s_q.mf_sel};
            `IOSC_OFS_TRIM:   rd_mux = {24'h0, s_q.lf_sel, 1'b0, s_q.tune};
            `IOSC_OFS_CFG:    rd_mux = {28'h0, s_q.power_up_timer_dis, s_q.mode};
            `IOSC_OFS_STATUS: rd_mux = {28'h0, s_q.st, ~s_q.hold};
            default:          rd_mux = 32'h0000_0000;
        endcase

        // bus: waitrequest drops one cycle after the request arrives
        s_d.wait_req = 1'b1;
        if (req && s_q.wait_req) begin
            s_d.wait_req = 1'b0;
            s_d.rdata    = i_avs_read ? rd_mux : 32'h0000_0000;
        end

        // writes land on the edge that sees waitrequest low
        if (wr_ok) begin
            case (i_avs_address)
                `IOSC_OFS_CTRL: begin
                    s_d.freq_sel = i_avs_writedata[`IOSC_FREQ_SEL_LSB +: 3];
                end
                `IOSC_OFS_CTRL2: begin
                    s_d.mf_sel = i_avs_writedata[`IOSC_MF_SEL_BIT];
                end
                `IOSC_OFS_TRIM: begin
                    s_d.tune   = i_avs_writedata[`IOSC_TUNE_LSB +: 6];
                    s_d.lf_sel = i_avs_writedata[`IOSC_LF_SEL_BIT];
                end
                `IOSC_OFS_CFG: begin
                    s_d.mode     = iosc_mode_t'(i_avs_writedata[`IOSC_MODE_LSB +: 3]);
                    s_d.power_up_timer_dis = i_avs_writedata[`IOSC_POWER_UP_TIMER_DIS_BIT];
                end
                default: begin
                    s_d.tune = s_d.tune;                                // unmapped, ignored
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q          <= '0;
            s_q.freq_sel <= `IOSC_FREQ_SEL_RST;
            s_q.mode     <= IOSC_MODE_INT;
            s_q.st       <= IOSC_ST_START;
            s_q.wait_req <= 1'b1;
            s_q.hold     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_avs_readdata    = s_q.rdata;
    assign o_avs_waitrequest = s_q.wait_req;
    assign o_int_tick        = s_q.int_tick;
    assign o_lf_tick         = s_q.lf_tick;
    assign o_primary_tick    = s_q.prim_tick;
    assign o_startup_hold    = s_q.hold;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    logic [11:0] lf_gap_q;                  // cycles since last low tick
    logic        lf_seen_q;                 // one low tick already seen
    logic        wrote_q;                   // freq select ever written

    // helper counters for the checks
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lf_gap_q  <= 12'h000;
            lf_seen_q <= 1'b0;
            wrote_q   <= 1'b0;
        end else begin
            lf_gap_q  <= o_lf_tick ? 12'h001 : lf_gap_q + 12'h001;
            lf_seen_q <= lf_seen_q | o_lf_tick;
            wrote_q   <= wrote_q | (wr_ok && i_avs_address == `IOSC_OFS_CTRL);
        end
    end

    chk_lf_period: assert property (o_lf_tick && lf_seen_q |-> lf_gap_q inside {12'hC80, 12'hC81})
        else $error("low source period off");
    chk_primary_lf: assert property (i_primary_sel_lf && src.lf |=> o_primary_tick)
        else $error("primary path missed low tick");
    chk_lf_always: assert property (src.lf |=> o_lf_tick)
        else $error("low tick not passed on");
    chk_hf_tap: assert property (s_q.freq_sel == 3'h7 && src.hf |=> o_int_tick)
        else $error("16 MHz selection missed a tick");
    chk_mf_route: assert property (s_q.freq_sel == 3'h2 && s_q.mf_sel |=> o_int_tick == $past(src.mf))
        else $error("500 kHz not from medium source");
    chk_reset_freq: assert property (!wrote_q |-> s_q.freq_sel == 3'h3)
        else $error("frequency select left 1 MHz unwritten");
    chk_trim_dir: assert property ($signed(s_q.tune) > $signed($past(s_q.tune)) |-> hf_inc > $past(hf_inc))
        else $error("raising trim did not raise rate");
    chk_pll_wait: assert property ($rose(s_q.st == IOSC_ST_RUN) && s_q.mode == IOSC_MODE_XPLL
                                   |-> $past(s_q.st) == IOSC_ST_PLL)
        else $error("pll mode released without lock wait");
    chk_power_up_timer_skip: assert property (s_q.st == IOSC_ST_START && (s_q.power_up_timer_dis || s_q.pm_evt) && !i_bor
                                    |=> s_q.st != IOSC_ST_POWER_UP_TIMER)
        else $error("power-up delay taken when disabled");
    chk_ost_mode: assert property (s_q.st == IOSC_ST_OST |-> is_crystal(s_q.mode))
        else $error("start-up count in a non-crystal mode");
    chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");

    cov_ready: cover property ($fell(o_startup_hold));
    cov_pll: cover property (s_q.st == IOSC_ST_PLL ##1 s_q.st == IOSC_ST_RUN);
    cov_hf31k: cover property (s_q.freq_sel == 3'h0 && s_q.lf_sel && !s_q.mf_sel && o_int_tick);
    cov_pm_exit: cover property (s_q.st == IOSC_ST_RUN && i_pm_exit);

endmodule // iosc_top

`default_nettype wire

// File: iosc_top_tb_top.sv
// iosc_top_tb_top.sv : self-checking bench for the oscillator select block.
// assumes: iosc_pkg and iosc_top compiled first; start-up counts shortened.
`timescale 1ns/1ps
`default_nettype none
module iosc_top_tb_top;
    import iosc_pkg::*;
    // ------------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------------
    logic        i_clk = 1'b0, i_resetn = 1'b0;
    logic [4:0]  i_avs_address = 5'h00;
    logic        i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest, o_int_tick, o_lf_tick, o_primary_tick, o_startup_hold;
    logic        i_bor = 1'b0, i_pm_exit = 1'b0, i_osc_tick = 1'b0, i_primary_sel_lf = 1'b0;
    int          err_total = 0, n_tests = 0, ni, np, nl, n, e, s, k;
    int          wv[3] = '{25600, 6400, 6400};     // window per 31 kHz source
    logic [7:0]  tv[3] = '{8'h20, 8'h80, 8'h80};   // trim: low src (tuned down), then low sel set
    logic [7:0]  mv[3] = '{8'h01, 8'h01, 8'h00};   // medium sel per case
    always #5 i_clk = ~i_clk;                      // 100 MHz
    iosc_top #(.POWER_UP_TIMER_LF_TICKS(24'h4), .OST_PERIODS(24'h8), .PLL_LOCK_CYCLES(24'h14)) u_iosc_top (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_bor(i_bor),
        .i_pm_exit(i_pm_exit), .i_osc_tick(i_osc_tick), .i_primary_sel_lf(i_primary_sel_lf),
        .o_int_tick(o_int_tick), .o_lf_tick(o_lf_tick), .o_primary_tick(o_primary_tick),
        .o_startup_hold(o_startup_hold));
    // ------------------------------------------------------------------
    // report, compare and bus tasks
    // ------------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_eq(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        n_tests++;
        if (sn !== ex) begin
            $display("ERROR %s expected %h seen %h", nm, ex, sn);
            err_total++;
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int sn);
        n_tests++;
        if (sn < lo || sn > hi) begin
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, sn);
            err_total++;
        end
    endtask
    // one avalon transfer: hold until waitrequest low is sampled at an edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int c;
        c = 0;
        i_avs_address <= a; i_avs_write <= wr; i_avs_read <= !wr;
        i_avs_writedata <= d; i_avs_byteenable <= be;
        do begin @(posedge i_clk); c++; end while (o_avs_waitrequest !== 1'b0 && c < 50);
        q = o_avs_readdata;
        if (o_avs_waitrequest !== 1'b0) begin err_total++; results(); end
        i_avs_read <= 1'b0; i_avs_write <= 1'b0;
        @(posedge i_clk);                          // idle edge between transfers
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, be, q);
    endtask
    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] ex);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk_eq(nm, ex, q);
    endtask
    // count tick pulses over a window of clock cycles
    task automatic measure(input int w);
        ni = 0; np = 0; nl = 0;
        repeat (w) begin
            @(posedge i_clk);
            ni += int'(o_int_tick === 1'b1); np += int'(o_primary_tick === 1'b1); nl += int'(o_lf_tick === 1'b1);
        end
    endtask
    task automatic wait_hold(input int mx);
        n = 0;
        while (o_startup_hold !== 1'b0) begin
            @(posedge i_clk); n++;
            if (n > mx) begin err_total++; results(); end
        end
    endtask
    // one-cycle event pulse: 0 brown-out, 1 oscillator tick, 2 power-managed exit
    task automatic pulse(input int w);
        if (w == 0) i_bor <= 1'b1;
        else if (w == 1) i_osc_tick <= 1'b1;
        else i_pm_exit <= 1'b1;
        @(posedge i_clk);
        i_bor <= 1'b0; i_osc_tick <= 1'b0; i_pm_exit <= 1'b0;
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        rd_chk("ctrl", 5'h00, 32'h3);
        rd_chk("ctrl2", 5'h04, 32'h0);
        rd_chk("trim", 5'h08, 32'h0);
        rd_chk("cfg", 5'h0C, 32'h4);
        rd_chk("stat", 5'h10, 32'h2);
        rd_chk("unmap", 5'h14, 32'h0);
        wait_hold(20000);
        chk_rng("power_up_timer", 9000, 13000, n);
        rd_chk("stat", 5'h10, 32'h9);
        wr(5'h00, 8'h07, 4'h0);
        wr(5'h14, 8'hFF);
        rd_chk("ctrl", 5'h00, 32'h3);
        for (s = 7; s >= 1; s--) begin    // high source taps
            wr(5'h00, 8'(s)); measure(3200); e = 512 >> (7 - s);
            chk_rng("int", e - e / 16 - 2, e + e / 16 + 2, ni);
            chk_rng("prim", ni, ni, np);
        end
        wr(5'h04, 8'h01);                 // medium source for 500k and 250k
        for (s = 2; s >= 1; s--) begin
            wr(5'h00, 8'(s)); measure(3200); e = 16 >> (2 - s);
            chk_rng("int_mf", e - 2, e + 2, ni);
        end
        wr(5'h00, 8'h00);
        for (k = 0; k < 3; k++) begin     // 31 kHz from low, medium, high
            wr(5'h08, tv[k]); wr(5'h04, mv[k]); measure(wv[k]); e = wv[k] / 3200;
            chk_rng("int31k", e - 1, e + 1, ni);
            chk_rng("lf", e - 1, e + 1, nl);
        end
        i_primary_sel_lf <= 1'b1;
        wr(5'h00, 8'h07); wr(5'h08, 8'h1F); measure(3200);
        chk_rng("trim_up", 626, 646, ni);
        chk_rng("prim_lf", nl, nl, np);
        wr(5'h08, 8'h20); measure(3200);
        chk_rng("trim_dn", 374, 394, ni);
        i_primary_sel_lf <= 1'b0;
        wr(5'h0C, 8'h08);                  // pll mode, power-up delay off
        pulse(0);
        repeat (3) @(posedge i_clk);
        repeat (7) begin pulse(1); repeat (2) @(posedge i_clk); end
        chk_eq("ost_hold", 32'h1, {31'h0, o_startup_hold});
        rd_chk("ost_st", 5'h10, 32'h4);
        pulse(1);
        wait_hold(100);
        chk_rng("pll", 19, 24, n);
        wr(5'h0C, 8'h04);                  // internal mode, delay enabled
        pulse(2);
        n = 0;
        repeat (10) begin @(posedge i_clk); n += int'(o_startup_hold === 1'b1); end
        chk_rng("pm_hold", 1, 1, n);
        wr(5'h0C, 8'h09);                  // crystal without pll, delay off
        pulse(0);
        @(posedge i_clk);                  // start state takes no tick
        repeat (8) begin pulse(1); @(posedge i_clk); end
        rd_chk("xtal_run", 5'h10, 32'h9);
        wr(5'h0C, 8'h0B);                  // external rc, delay off
        pulse(0);
        repeat (2) @(posedge i_clk);
        rd_chk("rc_run", 5'h10, 32'h9);
        results();
    end
endmodule // iosc_top_tb_top
`default_nettype wire
